// >>> bsc_pkg.sv
// constants, types and tables of the buck start/stop and sync control
// assumes a 25 MHz system clock; all users reference names as bsc_pkg::name
package bsc_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int STEP_US = 250;
  localparam int STEP_CYC = CLK_HZ / 1_000_000 * STEP_US;
  localparam logic [6:0] FALL_ZERO_CODE = 7'h02;
  localparam logic [7:0] LS_FULL = 8'h80;
  localparam logic [4:0] SYNC_DET_PERIODS = 5'h10;
  // register byte addresses
  localparam logic [7:0] A_OPER = 8'h00;
  localparam logic [7:0] A_ONOFF = 8'h04;
  localparam logic [7:0] A_VCMD = 8'h08;
  localparam logic [7:0] A_TRIM = 8'h0c;
  localparam logic [7:0] A_MHI = 8'h10;
  localparam logic [7:0] A_MLO = 8'h14;
  localparam logic [7:0] A_SCALE = 8'h18;
  localparam logic [7:0] A_TRISE = 8'h1c;
  localparam logic [7:0] A_TFALL = 8'h20;
  localparam logic [7:0] A_FREQ = 8'h24;
  localparam logic [7:0] A_STAT = 8'h28;
  // field positions
  localparam int OP_ON = 7;
  localparam int OP_SOFT = 6;
  localparam int OP_MHI = 5;
  localparam int OP_MLO = 4;
  localparam int OO_PIN = 0;
  localparam int OO_CMD = 1;
  localparam int OO_PSOFT = 2;
  // reset values
  localparam logic [7:0] OPER_RST = 8'h00;
  localparam logic [2:0] ONOFF_RST = 3'h3;
  localparam logic [15:0] VCMD_RST = 16'h0000;
  localparam logic [15:0] MARGIN_RST = 16'h0000;
  typedef enum logic [1:0] {ST_OFF = 2'h0, ST_RISE = 2'h1, ST_ON = 2'h3,
    ST_FALL = 2'h2} bsc_state_t;
  typedef enum logic [1:0] {SM_AUTO = 2'h0, SM_IN = 2'h1,
    SM_OUT = 2'h2} bsc_smode_t;
  typedef struct packed {
    logic [3:0] freq;
    logic [6:0] ton;
    logic [2:0] phase;
    bsc_smode_t mode;
  } bsc_strap_t;
  typedef struct packed {
    logic [2:0] freq;
    logic [2:0] ton;
    logic [2:0] slave_code;
    logic addr_open;
    logic [3:0] addr_code;
    logic slave;
  } bsc_pins_t;
  // switching period in clk_sys cycles for each frequency code
  function automatic logic [7:0] fsw_cyc(input logic [3:0] c);
    unique case (c)
      4'h0: fsw_cyc = 8'(CLK_HZ / 225_000);
      4'h1: fsw_cyc = 8'(CLK_HZ / 250_000);
      4'h2: fsw_cyc = 8'(CLK_HZ / 275_000);
      4'h3: fsw_cyc = 8'(CLK_HZ / 300_000);
      4'h4: fsw_cyc = 8'(CLK_HZ / 325_000);
      4'h5: fsw_cyc = 8'(CLK_HZ / 375_000);
      4'h6: fsw_cyc = 8'(CLK_HZ / 400_000);
      4'h7: fsw_cyc = 8'(CLK_HZ / 450_000);
      4'h8: fsw_cyc = 8'(CLK_HZ / 500_000);
      4'h9: fsw_cyc = 8'(CLK_HZ / 550_000);
      4'ha: fsw_cyc = 8'(CLK_HZ / 650_000);
      4'hb: fsw_cyc = 8'(CLK_HZ / 750_000);
      4'hc: fsw_cyc = 8'(CLK_HZ / 900_000);
      4'hd: fsw_cyc = 8'(CLK_HZ / 1_000_000);
      4'he: fsw_cyc = 8'(CLK_HZ / 1_100_000);
      4'hf: fsw_cyc = 8'(CLK_HZ / 1_500_000);
    endcase
  endfunction
endpackage

// >>> bsc_ramp.sv
// reference ramp engine for soft start and soft stop
// assumes go pulses are single cycle and target is steady during a ramp
`timescale 1ns/100ps
`default_nettype none
module bsc_ramp (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] target,
  input wire logic [6:0] code,
  input wire logic go_up,
  input wire logic go_down,
  output logic [15:0] ref_level,
  output logic busy
);
  typedef struct packed {
    logic [15:0] lvl;
    logic [19:0] acc;
    logic [19:0] left;
    logic up;
    logic busy;
  } bsc_ramp_st_t;
  bsc_ramp_st_t s_r, s_nxt;
  logic [19:0] total;
  logic [20:0] sum;
  assign total = 20'(code * bsc_pkg::STEP_CYC);
  assign sum = {1'b0, s_r.acc} + {5'h00, target};
  // equal steps: the accumulator spreads target over the total cycles
  always_comb
  begin
    s_nxt = s_r;
    if (go_up || go_down)
    begin
      s_nxt.up = go_up;
      s_nxt.acc = '0;
      s_nxt.left = total;
      s_nxt.busy = (total != 20'h00000);
      if (go_up)
        s_nxt.lvl = (total == 20'h00000) ? target : 16'h0000;
      else if (total == 20'h00000)
        s_nxt.lvl = 16'h0000;
    end
    else if (s_r.busy)
    begin
      s_nxt.left = s_r.left - 20'h00001;
      if (sum >= {1'b0, total})
      begin
        s_nxt.acc = 20'(sum - {1'b0, total});
        s_nxt.lvl = s_r.up ? s_r.lvl + 16'h0001 : s_r.lvl - 16'h0001;
      end
      else
        s_nxt.acc = sum[19:0];
      // snap so the end point lands exactly when the time runs out
      if (s_r.left == 20'h00001)
      begin
        s_nxt.busy = 1'b0;
        s_nxt.lvl = s_r.up ? target : 16'h0000;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign ref_level = s_r.lvl;
  assign busy = s_r.busy;
endmodule
`default_nettype wire

// >>> bsc_sync.sv
// switching oscillator with sync pin direction, phase offset and loss check
// assumes sync_in is synchronous to clk_sys and slower than clk_sys / 4
`timescale 1ns/100ps
`default_nettype none
module bsc_sync (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic strap_done,
  input wire bsc_pkg::bsc_smode_t mode,
  input wire logic [3:0] freq,
  input wire logic [2:0] phase,
  input wire logic stacked,
  input wire logic osc_slow,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic sync_is_in,
  output logic sync_lost,
  output logic sw_tick
);
  typedef struct packed {
    logic [8:0] cnt;
    logic [9:0] gap;
    logic [4:0] det;
    logic prev;
    logic seen_hi;
    logic resolved;
    logic is_in;
    logic lost;
    logic tick;
  } bsc_sync_st_t;
  bsc_sync_st_t s_r, s_nxt;
  logic [8:0] per;
  logic [8:0] lim;
  logic [8:0] offs;
  logic edge_in;
  assign per = {1'b0, bsc_pkg::fsw_cyc(freq)};
  // standalone fallback runs about 70 percent of nominal frequency
  assign lim = (s_r.lost && !stacked) ? 9'(per * 10 / 7) : per;
  assign edge_in = sync_in && !s_r.prev;
  // phase offset as a fraction of the period
  always_comb
  begin
    unique case (phase)
      3'h1: offs = 9'(per / 4);
      3'h2: offs = 9'(per / 3);
      3'h3: offs = 9'(per / 2);
      3'h4: offs = 9'(per * 2 / 3);
      3'h5: offs = 9'(per * 3 / 4);
      default: offs = 9'h000;
    endcase
  end
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.prev = sync_in;
    s_nxt.tick = 1'b0;
    if (s_r.cnt + 9'h001 >= lim)
    begin
      s_nxt.cnt = 9'h000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.cnt = s_r.cnt + 9'h001;
    // auto mode watches the pin for a while after pin detection
    if (strap_done && !s_r.resolved)
    begin
      if (mode != bsc_pkg::SM_AUTO)
      begin
        s_nxt.resolved = 1'b1;
        s_nxt.is_in = (mode == bsc_pkg::SM_IN);
      end
      else
      begin
        s_nxt.seen_hi = s_r.seen_hi | sync_in;
        if (s_r.tick)
          s_nxt.det = s_r.det + 5'h01;
        if (s_r.det == bsc_pkg::SYNC_DET_PERIODS)
        begin
          s_nxt.resolved = 1'b1;
          s_nxt.is_in = s_r.seen_hi;
        end
      end
    end
    // input mode: relock on edges, flag loss after two missing periods
    if (s_r.resolved && s_r.is_in)
    begin
      if (edge_in)
      begin
        s_nxt.gap = 10'h000;
        s_nxt.lost = osc_slow;
        s_nxt.cnt = offs;
      end
      else
      begin
        if (s_r.gap != 10'h3ff)
          s_nxt.gap = s_r.gap + 10'h001;
        if (s_r.gap > {per, 1'b0} || osc_slow)
          s_nxt.lost = 1'b1;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign sw_tick = s_r.tick;
  assign sync_out = (s_r.cnt < {1'b0, per[8:1]});
  assign sync_oe = s_r.resolved && !s_r.is_in;
  assign sync_is_in = s_r.is_in;
  assign sync_lost = s_r.lost;
endmodule
`default_nettype wire

// >>> bsc_top.sv
// buck start/stop sequencing, power good and switching clock control
// assumes synchronous pins, one clock, register port with 1-cycle read data
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - reference ramps from zero to target
// - rise time seven bits, quarter-ms steps
// - strap sets rise time, writes override
// - low side off until first high pulse
// - low side cap grows over 128 periods
// - overvoltage response even while disabled
// - soft stop ramps output down to zero
// - zero fall time acts as 0.5 ms
// - no soft stop: both drivers off
// - pin soft stop disabled after reset
// - power good released when all met
// - shutdown faults pull power good low
// - sixteen frequencies, eight by strap
// - strap frequencies 275 to 1500 kHz
// - sync pin is input or output
// - phase offsets of 0 to 270 degrees
// - address or start strap picks sync
// - slave phase from start strap
// - slaves always take sync as input
// - address strap code to phase map
// - auto mode samples the sync pin
// - sync loss: stop stacked, slow standalone
module bsc_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire bsc_pkg::bsc_pins_t strap_pins,
  input wire logic pin_detect,
  input wire logic en_pin,
  input wire logic driver_supply_ok,
  input wire logic out_above_ref,
  input wire logic out_over_ov_fault,
  input wire logic out_in_warn_window,
  input wire logic fault_shutdown,
  input wire logic hs_pulse,
  input wire logic osc_slow,
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  output logic power_good_output_o,
  output logic power_good_output_oe,
  output logic [15:0] ref_level,
  output logic hs_enable,
  output logic ls_enable,
  output logic [7:0] ls_on_cap,
  output logic ov_discharge,
  output logic sw_tick
);
  typedef struct packed {
    bsc_pkg::bsc_state_t st;
    logic [7:0] oper;
    logic [2:0] onoff;
    logic [15:0] vcmd;
    logic [15:0] trim;
    logic [15:0] mhi;
    logic [15:0] mlo;
    logic [1:0] scale;
    logic [6:0] trise;
    logic [6:0] tfall;
    logic [3:0] freq;
    logic trise_wr;
    logic freq_wr;
    bsc_pkg::bsc_strap_t strap;
    logic strap_done;
    logic hs_seen;
    logic ls_limit;
    logic [7:0] ls_cnt;
    logic rise_done;
    logic pg_oe;
    logic ovd;
    logic [15:0] rdata;
  } bsc_top_st_t;
  bsc_top_st_t s_r, s_nxt;
  logic rst_n;
  logic [15:0] tgt;
  logic [15:0] sel;
  logic [15:0] ramp_ref;
  logic ramp_busy;
  logic go_up;
  logic go_down;
  logic [6:0] ramp_code;
  logic pin_on;
  logic cmd_on;
  logic want_on;
  logic sync_stop;
  logic sync_lost;
  logic sync_is_in;
  bsc_pkg::bsc_strap_t strap_dec;
  // reset release through two flops; the rest runs on the released copy
  logic [1:0] rst_pipe_r;
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      rst_pipe_r <= 2'h0;
    else
      rst_pipe_r <= {rst_pipe_r[0], 1'b1};
  end
  assign rst_n = rst_pipe_r[1];
  // strap code decoders
  function automatic logic [3:0] freq_strap(input logic [2:0] c);
    unique case (c)
      3'h0: freq_strap = 4'h2;
      3'h1: freq_strap = 4'h4;
      3'h2: freq_strap = 4'h7;
      3'h3: freq_strap = 4'h9;
      3'h4: freq_strap = 4'ha;
      3'h5: freq_strap = 4'hc;
      3'h6: freq_strap = 4'he;
      3'h7: freq_strap = 4'hf;
    endcase
  endfunction
  // eight rise-time strap choices in quarter-ms codes
  function automatic logic [6:0] ton_strap(input logic [2:0] c);
    unique case (c)
      3'h0: ton_strap = 7'h00;
      3'h1: ton_strap = 7'h02;
      3'h2: ton_strap = 7'h04;
      3'h3: ton_strap = 7'h08;
      3'h4: ton_strap = 7'h0c;
      3'h5: ton_strap = 7'h10;
      3'h6: ton_strap = 7'h20;
      3'h7: ton_strap = 7'h40;
    endcase
  endfunction
  // decode the straps; slaves take phase from the start strap
  always_comb
  begin
    strap_dec.freq = freq_strap(strap_pins.freq);
    strap_dec.ton = ton_strap(strap_pins.ton);
    strap_dec.phase = 3'h0;
    strap_dec.mode = bsc_pkg::SM_IN;
    if (strap_pins.slave)
    begin
      strap_dec.phase = (strap_pins.slave_code > 3'h5) ? 3'h0 :
        strap_pins.slave_code;
      strap_dec.mode = bsc_pkg::SM_IN;
    end
    else if (strap_pins.addr_open)
      strap_dec.mode = bsc_pkg::SM_AUTO;
    else
    begin
      unique case (strap_pins.addr_code[3:1])
        3'h0: strap_dec.phase = 3'h0;
        3'h1: strap_dec.phase = 3'h1;
        3'h2: strap_dec.phase = 3'h2;
        3'h3: strap_dec.phase = 3'h3;
        3'h4: strap_dec.phase = 3'h4;
        3'h5: strap_dec.phase = 3'h5;
        3'h6: strap_dec.phase = 3'h0;
        3'h7: strap_dec.phase = 3'h3;
      endcase
      if (strap_pins.addr_code[3:1] >= 3'h6)
        strap_dec.mode = bsc_pkg::SM_OUT;
    end
  end
  // target: margin select, trim, then the loop divider shift
  always_comb
  begin
    if (s_r.oper[bsc_pkg::OP_MHI])
      sel = s_r.mhi;
    else if (s_r.oper[bsc_pkg::OP_MLO])
      sel = s_r.mlo;
    else
      sel = s_r.vcmd;
    tgt = (sel + s_r.trim) >> s_r.scale;
  end
  // enable sources as configured; sync loss stops a stacked part
  assign pin_on = !s_r.onoff[bsc_pkg::OO_PIN] || en_pin;
  assign cmd_on = !s_r.onoff[bsc_pkg::OO_CMD] || s_r.oper[bsc_pkg::OP_ON];
  assign sync_stop = sync_lost && sync_is_in && strap_pins.slave;
  assign want_on = pin_on && cmd_on && driver_supply_ok && s_r.strap_done;
  assign go_up = (s_r.st == bsc_pkg::ST_OFF) && s_nxt.st == bsc_pkg::ST_RISE;
  assign go_down = (s_r.st != bsc_pkg::ST_FALL) &&
    (s_nxt.st == bsc_pkg::ST_FALL);
  // zero fall code is stretched to FALL_ZERO_CODE, a 0.5 ms fall
  assign ramp_code = go_down ? ((s_r.tfall == 7'h00) ?
    bsc_pkg::FALL_ZERO_CODE : s_r.tfall) : s_r.trise;
  // sequencing, drivers, power good and register writes
  always_comb
  begin
    s_nxt = s_r;
    // straps are caught once; later writes still replace the choice
    if (pin_detect && !s_r.strap_done)
    begin
      s_nxt.strap_done = 1'b1;
      s_nxt.strap = strap_dec;
      if (!s_r.trise_wr)
        s_nxt.trise = strap_dec.ton;
      if (!s_r.freq_wr)
        s_nxt.freq = strap_dec.freq;
    end
    unique case (s_r.st)
      bsc_pkg::ST_OFF:
        if (want_on && !fault_shutdown && !sync_stop)
          s_nxt.st = bsc_pkg::ST_RISE;
      bsc_pkg::ST_RISE, bsc_pkg::ST_ON:
      begin
        if (s_r.st == bsc_pkg::ST_RISE && !ramp_busy)
          s_nxt.st = bsc_pkg::ST_ON;
        if (fault_shutdown || sync_stop || !driver_supply_ok)
          s_nxt.st = bsc_pkg::ST_OFF;
        else if (!pin_on && s_r.onoff[bsc_pkg::OO_PSOFT])
          s_nxt.st = bsc_pkg::ST_FALL;
        else if (!pin_on)
          s_nxt.st = bsc_pkg::ST_OFF;
        else if (!cmd_on && s_r.oper[bsc_pkg::OP_SOFT])
          s_nxt.st = bsc_pkg::ST_FALL;
        else if (!cmd_on)
          s_nxt.st = bsc_pkg::ST_OFF;
      end
      bsc_pkg::ST_FALL:
        if (fault_shutdown || !driver_supply_ok || !ramp_busy)
          s_nxt.st = bsc_pkg::ST_OFF;
    endcase
    // rise time complete only after the ramp ends while running
    if (s_nxt.st == bsc_pkg::ST_ON)
      s_nxt.rise_done = 1'b1;
    else if (s_nxt.st != bsc_pkg::ST_ON)
      s_nxt.rise_done = 1'b0;
    // low side waits for a high pulse, then its cap widens per period
    if (s_nxt.st == bsc_pkg::ST_OFF || s_r.st == bsc_pkg::ST_OFF)
    begin
      s_nxt.hs_seen = 1'b0;
      s_nxt.ls_limit = 1'b0;
      s_nxt.ls_cnt = 8'h00;
    end
    else
    begin
      if (hs_pulse)
        s_nxt.hs_seen = 1'b1;
      if (s_r.hs_seen && out_above_ref)
        s_nxt.ls_limit = 1'b1;
      if (s_r.ls_limit && sw_tick && s_r.ls_cnt != bsc_pkg::LS_FULL)
        s_nxt.ls_cnt = s_r.ls_cnt + 8'h01;
    end
    // overvoltage watch runs once the straps are caught and the driver supply is good
    s_nxt.ovd = s_r.strap_done && driver_supply_ok && out_over_ov_fault;
    // power good: pulled low unless every release term holds
    s_nxt.pg_oe = !(s_nxt.st == bsc_pkg::ST_ON && s_nxt.rise_done &&
      out_in_warn_window && !fault_shutdown);
    if (reg_wr)
    begin
      unique case (reg_addr)
        bsc_pkg::A_OPER: s_nxt.oper = reg_wdata[7:0];
        bsc_pkg::A_ONOFF: s_nxt.onoff = reg_wdata[2:0];
        bsc_pkg::A_VCMD: s_nxt.vcmd = reg_wdata;
        bsc_pkg::A_TRIM: s_nxt.trim = reg_wdata;
        bsc_pkg::A_MHI: s_nxt.mhi = reg_wdata;
        bsc_pkg::A_MLO: s_nxt.mlo = reg_wdata;
        bsc_pkg::A_SCALE: s_nxt.scale = reg_wdata[1:0];
        bsc_pkg::A_TRISE:
        begin
          s_nxt.trise = reg_wdata[6:0];
          s_nxt.trise_wr = 1'b1;
        end
        bsc_pkg::A_TFALL: s_nxt.tfall = reg_wdata[6:0];
        bsc_pkg::A_FREQ:
        begin
          s_nxt.freq = reg_wdata[3:0];
          s_nxt.freq_wr = 1'b1;
        end
        default: s_nxt.freq_wr = s_r.freq_wr;
      endcase
    end
    // read data stand only in the cycle after the strobe
    s_nxt.rdata = 16'h0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        bsc_pkg::A_OPER: s_nxt.rdata = {8'h00, s_r.oper};
        bsc_pkg::A_ONOFF: s_nxt.rdata = {13'h0000, s_r.onoff};
        bsc_pkg::A_VCMD: s_nxt.rdata = s_r.vcmd;
        bsc_pkg::A_TRIM: s_nxt.rdata = s_r.trim;
        bsc_pkg::A_MHI: s_nxt.rdata = s_r.mhi;
        bsc_pkg::A_MLO: s_nxt.rdata = s_r.mlo;
        bsc_pkg::A_SCALE: s_nxt.rdata = {14'h0000, s_r.scale};
        bsc_pkg::A_TRISE: s_nxt.rdata = {9'h000, s_r.trise};
        bsc_pkg::A_TFALL: s_nxt.rdata = {9'h000, s_r.tfall};
        bsc_pkg::A_FREQ: s_nxt.rdata = {12'h000, s_r.freq};
        bsc_pkg::A_STAT: s_nxt.rdata = {5'h00, s_r.strap.phase,
          s_r.st, sync_lost, sync_is_in, s_r.ovd, !s_r.pg_oe,
          s_r.rise_done, s_r.strap_done};
        default: s_nxt.rdata = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.st <= bsc_pkg::ST_OFF;
      s_r.oper <= bsc_pkg::OPER_RST;
      s_r.onoff <= bsc_pkg::ONOFF_RST;
      s_r.vcmd <= bsc_pkg::VCMD_RST;
      s_r.mhi <= bsc_pkg::MARGIN_RST;
      s_r.mlo <= bsc_pkg::MARGIN_RST;
      s_r.strap.mode <= bsc_pkg::SM_AUTO;
      s_r.pg_oe <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end
  bsc_ramp u_ramp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .target(tgt),
    .code(ramp_code),
    .go_up(go_up),
    .go_down(go_down),
    .ref_level(ramp_ref),
    .busy(ramp_busy)
  );
  bsc_sync u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .strap_done(s_r.strap_done),
    .mode(s_r.strap.mode),
    .freq(s_r.freq),
    .phase(s_r.strap.phase),
    .stacked(strap_pins.slave),
    .osc_slow(osc_slow),
    .sync_in(sync_in),
    .sync_out(sync_out),
    .sync_oe(sync_oe),
    .sync_is_in(sync_is_in),
    .sync_lost(sync_lost),
    .sw_tick(sw_tick)
  );
  // drivers off at once in the off state; soft stop keeps both running
  assign hs_enable = (s_r.st != bsc_pkg::ST_OFF);
  assign ls_enable = hs_enable && s_r.hs_seen;
  assign ls_on_cap = s_r.ls_limit ? s_r.ls_cnt : 8'h00;
  assign ref_level = ramp_ref;
  assign ov_discharge = s_r.ovd;
  assign power_good_output_o = 1'b0;
  assign power_good_output_oe = s_r.pg_oe;
  assign reg_rdata = s_r.rdata;
endmodule
`default_nettype wire

// >>> bsc_top_monitor.sv
// checker on the top ports of the start/stop and sync block
// assumes one clk_sys domain with reset_n as its reset
`timescale 1ns/100ps
`default_nettype none
module bsc_top_monitor (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire bsc_pkg::bsc_pins_t strap_pins,
  input wire logic out_over_ov_fault,
  input wire logic driver_supply_ok,
  input wire logic out_in_warn_window,
  input wire logic fault_shutdown,
  input wire logic sync_oe,
  input wire logic power_good_output_oe,
  input wire logic hs_enable,
  input wire logic ls_enable,
  input wire logic [7:0] ls_on_cap,
  input wire logic ov_discharge,
  input wire logic sw_tick
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // power good is registered, so its cause is one cycle back
  a_pg_window: assert property (!power_good_output_oe |-> $past(out_in_warn_window))
    else $error("power good released outside window");
  a_fault_pg: assert property (fault_shutdown |=> power_good_output_oe)
    else $error("power good not pulled on fault");
  a_ls_start: assert property ($rose(hs_enable) |-> !ls_enable)
    else $error("low side on at start");
  a_cap_max: assert property (ls_on_cap <= bsc_pkg::LS_FULL)
    else $error("low side cap too large");
  a_cap_step: assert property (ls_on_cap > $past(ls_on_cap) |->
    ls_on_cap == $past(ls_on_cap) + 8'h01)
    else $error("low side cap jumped");
  a_ov_resp: assert property (out_over_ov_fault && driver_supply_ok |->
    ##[0:4] ov_discharge)
    else $error("no overvoltage response");
  a_slave_in: assert property (strap_pins.slave |-> !sync_oe)
    else $error("slave drives sync");
  a_tick_pulse: assert property (sw_tick |=> !sw_tick)
    else $error("period tick too long");
endmodule
bind bsc_top bsc_top_monitor u_mon (.clk_sys, .reset_n, .strap_pins, .out_over_ov_fault,
  .driver_supply_ok, .out_in_warn_window, .fault_shutdown, .sync_oe, .power_good_output_oe,
  .hs_enable, .ls_enable, .ls_on_cap, .ov_discharge, .sw_tick);
`default_nettype wire

// >>> bsc_peer.sv
// peer converter sharing the sync pin, plus the power good pull-up
// assumes clk_sys; a silent sync pin is pulled down
`timescale 1ns/100ps
`default_nettype none
module bsc_peer (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [7:0] half,
  input wire logic dut_oe,
  input wire logic dut_out,
  input wire logic pg_oe,
  output logic sync_line,
  output logic pg_line
);
  logic [7:0] cnt_r = 8'h00;
  logic clk_r = 1'b0;
  // peer clock, seen on the pin only while the peer runs
  always_ff @(posedge clk_sys)
  begin
    cnt_r <= (cnt_r >= half) ? 8'h00 : cnt_r + 8'h01;
    if (cnt_r >= half)
      clk_r <= ~clk_r;
  end
  // a driving device wins; else the pull-down decides auto mode
  assign sync_line = dut_oe ? dut_out : (run & clk_r);
  assign pg_line = ~pg_oe;
endmodule
`default_nettype wire

// >>> bsc_top_tb.sv
// self-checking bench of the start/stop and sync block
// assumes package, design, checker and peer model compiled first
`timescale 1ns/100ps
`default_nettype none
module bsc_top_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, pin_detect = 1'b0, en_pin = 1'b0;
  logic [15:0] reg_rdata, ref_level, tgt, d;
  bsc_pkg::bsc_pins_t strap_pins = '0;
  logic driver_supply_ok = 1'b1, out_above_ref = 1'b0, out_over_ov_fault = 1'b0;
  logic out_in_warn_window = 1'b1, fault_shutdown = 1'b0, hs_pulse = 1'b0, osc_slow = 1'b0;
  logic run = 1'b0, sync_in, sync_out, sync_oe, pg, power_good_output_o, power_good_output_oe;
  logic hs_enable, ls_enable, ov_discharge, sw_tick;
  logic [7:0] ls_on_cap;
  logic [3:0] c;
  int err_count = 0, tests_run = 0, cyc = 0, seed, n, p;
  int khz[16] = '{225, 250, 275, 300, 325, 375, 400, 450, 500, 550, 650, 750, 900, 1000, 1100, 1500};
  bsc_top dut (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .strap_pins, .pin_detect, .en_pin, .driver_supply_ok, .out_above_ref, .out_over_ov_fault,
    .out_in_warn_window, .fault_shutdown, .hs_pulse, .osc_slow, .sync_in, .sync_out, .sync_oe,
    .power_good_output_o, .power_good_output_oe, .ref_level, .hs_enable, .ls_enable,
    .ls_on_cap, .ov_discharge, .sw_tick);
  bsc_peer peer (.clk_sys, .run, .half(8'd20), .dut_oe(sync_oe), .dut_out(sync_out),
    .pg_oe(power_good_output_oe), .sync_line(sync_in), .pg_line(pg));
  always #20 clk_sys = ~clk_sys;
  // one high-side pulse per switching period while enabled
  always @(posedge clk_sys)
    hs_pulse <= sw_tick & hs_enable;
  // hang guard, well above the expected run length
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return 16'(v >= lo && v <= hi);
  endfunction
  task automatic tk(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    tk(1);
    reg_wr <= 1'b0;
    tk(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    tk(1);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    tk(1);
  endtask
  // reset, then let pin detection and the sync auto watch finish
  task automatic boot(input logic r, input logic op, input logic [3:0] ac);
    reset_n <= 1'b0;
    pin_detect <= 1'b0;
    run <= r;
    strap_pins.addr_open <= op;
    strap_pins.addr_code <= ac;
    tk(12);
    reset_n <= 1'b1;
    tk(3);
    pin_detect <= 1'b1;
    tk(900);
  endtask
  // cycles from one period tick to the next
  task automatic per(output int q);
    q = 0;
    while (sw_tick !== 1'b1 && q < 300)
    begin
      tk(1);
      #1 q++;
    end
    q = 0;
    do
    begin
      tk(1);
      #1 q++;
    end
    while (sw_tick !== 1'b1 && q < 300);
  endtask
  // bounded wait: ramp at target, or high side off
  task automatic wt(input logic w, output int k);
    k = 0;
    while ((w ? hs_enable !== 1'b0 : ref_level !== tgt) && k < 30000)
    begin
      tk(1);
      #1 k++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    seed = 36500;
    strap_pins.freq = 3'h3;
    strap_pins.ton = 3'h2;
    for (int i = 0; i < 6; i++)
    begin
      boot(1'b1, 1'b0, 4'(i));
      rd(bsc_pkg::A_STAT, d);
      chk("sync_in", 16'h1, 16'(d[4]));
      chk("phase", 16'(i / 2), 16'(d[10:8]));
    end
    strap_pins.slave <= 1'b1;
    strap_pins.slave_code <= 3'h5;
    boot(1'b1, 1'b1, 4'h0);
    rd(bsc_pkg::A_STAT, d);
    chk("slave_in", 16'h1, 16'(d[4]));
    chk("slave_phase", 16'h5, 16'(d[10:8]));
    strap_pins.slave <= 1'b0;
    boot(1'b0, 1'b1, 4'h0);
    chk("sync_oe", 16'h1, 16'(sync_oe));
    rd(bsc_pkg::A_ONOFF, d);
    chk("onoff", 16'h3, d);
    rd(8'hfc, d);
    chk("unmapped", 16'h0, d);
    rd(bsc_pkg::A_TRISE, d);
    chk("rise_strap", 16'h4, d);
    per(p);
    chk("fsw_strap", 16'd45, 16'(p));
    chk("sync_out", 16'h1, 16'(sync_out));
    for (int k = 0; k < 4; k++)
    begin
      c = (k < 2) ? 4'(k * 15) : 4'($random(seed));
      wr(bsc_pkg::A_FREQ, 16'(c));
      per(p);
      per(p);
      chk("fsw", 16'(25000 / khz[c]), 16'(p));
    end
    $display("straps and frequency done");
    wr(bsc_pkg::A_TRISE, 16'h2);
    tgt = 16'($random(seed)) | 16'h0100;
    wr(bsc_pkg::A_VCMD, tgt);
    wr(bsc_pkg::A_OPER, 16'h0080);
    en_pin <= 1'b1;
    wt(1'b0, n);
    chk("rise_len", 16'h1, inr(n, 12500, 12506));
    tk(4);
    chk("pg_free", 16'h1, 16'(pg));
    out_above_ref <= 1'b1;
    n = 0;
    while (ls_on_cap !== bsc_pkg::LS_FULL && n < 300)
    begin
      per(p);
      n++;
    end
    chk("cap_len", 16'h1, inr(n, 126, 130));
    chk("ls_on", 16'h1, 16'(ls_enable));
    fault_shutdown <= 1'b1;
    tk(3);
    chk("fault_pg", 16'h0, 16'({pg, hs_enable, power_good_output_o}));
    fault_shutdown <= 1'b0;
    tk(12600);
    en_pin <= 1'b0;
    tk(3);
    chk("hard_stop", 16'h0, 16'({hs_enable, ls_enable}));
    $display("start and hard stop done");
    wr(bsc_pkg::A_ONOFF, 16'h7);
    wr(bsc_pkg::A_TFALL, 16'h0);
    en_pin <= 1'b1;
    tk(12600);
    en_pin <= 1'b0;
    tk(3);
    rd(bsc_pkg::A_STAT, d);
    chk("falling", 16'h2, 16'(d[7:6]));
    wt(1'b1, n);
    chk("fall_len", 16'h1, inr(n, 12480, 12510));
    out_over_ov_fault <= 1'b1;
    tk(5);
    chk("ov_resp", 16'h1, 16'(ov_discharge));
    $display("soft stop and overvoltage done");
    close_out();
  end
endmodule
`default_nettype wire
